// ==== src/uarbs_pkg.sv ====
// constants and types shared by the receive buffer and status block
package uarbs_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CS_A = 8'h00;
  localparam logic [7:0] OFF_CS_B = 8'h04;
  localparam logic [7:0] OFF_CS_C = 8'h08;
  localparam logic [7:0] OFF_RX_DATA = 8'h0c;

  // ctrl_status_a bit positions
  localparam int A_RX_COMPLETE = 7;
  localparam int A_FRAME_ERR = 4;
  localparam int A_OVERRUN = 3;
  localparam int A_PARITY_ERR = 2;

  // ctrl_status_b bit positions
  localparam int B_RX_IRQ_EN = 7;
  localparam int B_RX_EN = 4;
  localparam int B_CHAR_SIZE_HI = 2;
  localparam int B_RX_NINTH = 1;

  // ctrl_status_c bit positions
  localparam int C_PARITY_EN = 5;
  localparam int C_PARITY_ODD = 4;
  localparam int C_STOP_SEL = 3;
  localparam int C_CHAR_SIZE_HI = 2;
  localparam int C_CHAR_SIZE_LO = 1;

  // values after reset and write masks
  localparam logic [7:0] CS_B_RESET = 8'h00;
  localparam logic [7:0] CS_C_RESET = 8'h06;
  localparam logic [7:0] CS_B_WMASK = 8'hfd;

  // receive buffer geometry and entry layout
  localparam int FIFO_DEPTH = 2;
  localparam int ENTRY_W = 12;
  localparam int E_PARITY_ERR = 0;
  localparam int E_OVERRUN = 1;
  localparam int E_FRAME_ERR = 2;
  localparam int E_DATA_LO = 3;
  localparam int E_NINTH = 11;

  // character size codes
  localparam logic [2:0] CSZ_NINE = 3'h7;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_BASE = 4'h5;

  // frame assembly states
  typedef enum logic [1:0] {
    UARBS_IDLE = 2'b00,
    UARBS_RECV = 2'b01,
    UARBS_HOLD = 2'b10
  } uarbs_rx_state_t;

endpackage : uarbs_pkg

// ==== src/uarbs_fifo.sv ====
// two-entry receive buffer holding each frame with its status bits
module uarbs_fifo #(
  parameter int WIDTH = uarbs_pkg::ENTRY_W,
  parameter int DEPTH = uarbs_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [WIDTH-1:0] push_entry,
  input wire logic pop,
  output logic not_empty,
  output logic [WIDTH-1:0] head
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] count;
  } uarbs_fifo_state_t;

  uarbs_fifo_state_t s;
  uarbs_fifo_state_t next_s;

  assign push_ready = (s.count < CW'(DEPTH));
  assign not_empty = (s.count != '0);
  assign head = s.mem[0];

  // entry 0 is always the head; a pop shifts every entry down by one
  always_comb begin
    next_s = s;
    if (flush) begin
      next_s = '0;
    end else begin
      if (pop && not_empty) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          next_s.mem[i] = s.mem[i + 1];
        end
        next_s.mem[DEPTH-1] = '0;
        next_s.count = s.count - 1'b1;
      end
      // push_ready looks at the old count, so a full buffer refuses even
      // when a pop frees a slot in the same cycle
      if (push_valid && push_ready) begin
        next_s.mem[next_s.count] = push_entry;
        next_s.count = next_s.count + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : uarbs_fifo

// ==== src/uarbs_shift.sv ====
// receive shift register: assembles recovered bits into buffer entries
module uarbs_shift (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [3:0] data_bits,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic bit_start,
  input wire logic bit_valid,
  input wire logic bit_value,
  input wire logic push_ready,
  output logic push_valid,
  output logic [uarbs_pkg::ENTRY_W-1:0] push_entry
);

  typedef struct packed {
    uarbs_pkg::uarbs_rx_state_t state;
    logic [3:0] cnt;
    logic [8:0] data;
    logic par;
    logic fe;
    logic perr;
    logic ovr_pend;
  } uarbs_shift_state_t;

  uarbs_shift_state_t s;
  uarbs_shift_state_t next_s;

  assign push_valid = (s.state == uarbs_pkg::UARBS_HOLD);
  assign push_entry = {s.data, s.fe, s.ovr_pend, s.perr};

  always_comb begin
    next_s = s;
    if (!enable) begin
      next_s = '0;
    end else begin
      case (s.state)
        uarbs_pkg::UARBS_IDLE: begin
          if (bit_start) begin
            next_s.state = uarbs_pkg::UARBS_RECV;
            next_s.cnt = '0;
            next_s.data = '0;
            next_s.par = 1'b0;
          end
        end
        uarbs_pkg::UARBS_RECV: begin
          if (bit_valid) begin
            next_s.cnt = s.cnt + 1'b1;
            if (s.cnt < data_bits) begin
              next_s.data[s.cnt] = bit_value;
              next_s.par = s.par ^ bit_value;
            end else if (parity_en && s.cnt == data_bits) begin
              next_s.par = s.par ^ bit_value;
            end else begin
              // first stop bit ends the frame; later stop bits never seen
              next_s.fe = ~bit_value;
              next_s.perr = parity_en & (s.par ^ parity_odd);
              next_s.state = uarbs_pkg::UARBS_HOLD;
            end
          end
        end
        uarbs_pkg::UARBS_HOLD: begin
          if (push_ready) begin
            next_s.ovr_pend = 1'b0;
            next_s.state = bit_start ? uarbs_pkg::UARBS_RECV
                                     : uarbs_pkg::UARBS_IDLE;
            next_s.cnt = '0;
            next_s.data = '0;
            next_s.par = 1'b0;
          end else if (bit_start) begin
            // buffer full, frame waiting, new start: waiting frame is lost
            next_s.ovr_pend = 1'b1;
            next_s.state = uarbs_pkg::UARBS_RECV;
            next_s.cnt = '0;
            next_s.data = '0;
            next_s.par = 1'b0;
          end
        end
        default: begin
          next_s = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : uarbs_shift

// ==== src/uarbs_top.sv ====
// uart receive buffer and status registers behind an apb slave
//
// Summary of operation
// - data read advances buffer and its status
// - receive complete flag shows buffer not empty
// - clearing receiver enable flushes the buffer
// - interrupt requested while flag and enable set
// - error flags travel in buffer with frame
// - writes cannot change error flags
// - error flags never raise an interrupt
// - frame error is inverse of first stop
// - frame error ignores stop bit count setting
// - overrun on full buffer, waiting frame, start
// - overrun marks frames lost before this one
// - overrun clears on successful frame transfer
// - parity error zero while checking is off
// - upper mode bit enables, lower picks type
// - parity computed, compared, stored with data
// - parity error valid until data read
// - disabling receiver abandons reception at once
// - disabled receiver releases the receive pin
// - first stop bit moves frame into buffer
//
// The APB interface to the registers and the register offsets were left to the implementer.
module uarbs_top #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_start,
  input wire logic bit_valid,
  input wire logic bit_value,
  output logic rx_complete_irq,
  output logic rx_pin_override
);

  typedef struct packed {
    logic [7:0] cs_b;
    logic [7:0] cs_c;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pop_armed;
    logic irq;
    logic override;
  } uarbs_top_state_t;

  uarbs_top_state_t s;
  uarbs_top_state_t next_s;

  // control fields decoded from the stored control registers
  logic rx_enable_bit;
  logic rx_complete_irq_enable;
  logic parity_enable_bit;
  logic parity_odd_select;
  logic stop_bit_select;
  logic [2:0] char_size_field;
  logic [3:0] data_bits;

  // buffer and shift register connections
  logic fifo_flush;
  logic fifo_pop;
  logic fifo_not_empty;
  logic fifo_push_ready;
  logic shift_push_valid;
  logic [uarbs_pkg::ENTRY_W-1:0] shift_entry;
  logic [uarbs_pkg::ENTRY_W-1:0] head;

  // status of the next readable frame
  logic rx_complete_flag;
  logic frame_error_flag;
  logic overrun_flag;
  logic parity_error_flag;
  logic rx_ninth_bit;
  logic [7:0] rx_data_byte;

  // apb phase decode
  logic setup_phase;
  logic access_done;
  logic [7:0] addr8;
  logic [7:0] rd_byte;
  logic addr_ok;

  assign rx_enable_bit = s.cs_b[uarbs_pkg::B_RX_EN];
  assign rx_complete_irq_enable = s.cs_b[uarbs_pkg::B_RX_IRQ_EN];
  assign parity_enable_bit = s.cs_c[uarbs_pkg::C_PARITY_EN];
  assign parity_odd_select = s.cs_c[uarbs_pkg::C_PARITY_ODD];
  // stop bit count is stored but has no effect on reception
  assign stop_bit_select = s.cs_c[uarbs_pkg::C_STOP_SEL];
  assign char_size_field = {s.cs_b[uarbs_pkg::B_CHAR_SIZE_HI],
                            s.cs_c[uarbs_pkg::C_CHAR_SIZE_HI],
                            s.cs_c[uarbs_pkg::C_CHAR_SIZE_LO]};

  // character length; reserved size codes fall back to eight bits
  always_comb begin
    if (char_size_field == uarbs_pkg::CSZ_NINE) begin
      data_bits = uarbs_pkg::BITS_NINE;
    end else if (!char_size_field[2]) begin
      data_bits = uarbs_pkg::BITS_BASE + {2'b00, char_size_field[1:0]};
    end else begin
      data_bits = uarbs_pkg::BITS_EIGHT;
    end
  end

  // a disabled receiver empties the buffer every cycle it stays off
  assign fifo_flush = ~rx_enable_bit;

  uarbs_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .enable(rx_enable_bit),
    .data_bits(data_bits),
    .parity_en(parity_enable_bit),
    .parity_odd(parity_odd_select),
    .bit_start(bit_start),
    .bit_valid(bit_valid),
    .bit_value(bit_value),
    .push_ready(fifo_push_ready),
    .push_valid(shift_push_valid),
    .push_entry(shift_entry)
  );

  uarbs_fifo #(
    .WIDTH(uarbs_pkg::ENTRY_W),
    .DEPTH(uarbs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(fifo_flush),
    .push_valid(shift_push_valid),
    .push_ready(fifo_push_ready),
    .push_entry(shift_entry),
    .pop(fifo_pop),
    .not_empty(fifo_not_empty),
    .head(head)
  );

  // status fields come from the buffer head; an empty buffer shows zeros
  assign rx_complete_flag = fifo_not_empty;
  assign frame_error_flag = fifo_not_empty
                          & head[uarbs_pkg::E_FRAME_ERR];
  assign overrun_flag = fifo_not_empty
                      & head[uarbs_pkg::E_OVERRUN];
  assign parity_error_flag = fifo_not_empty
                           & head[uarbs_pkg::E_PARITY_ERR];
  assign rx_ninth_bit = fifo_not_empty & head[uarbs_pkg::E_NINTH];
  assign rx_data_byte = fifo_not_empty
                      ? head[uarbs_pkg::E_DATA_LO +: 8] : 8'h00;

  // apb phases: read data and answer are prepared in the setup cycle
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & s.pready;
  assign addr8 = 8'(paddr);

  // the pop is armed in setup so a frame landing in between is not lost
  assign fifo_pop = access_done & ~pwrite & s.pop_armed;

  // address decode and read multiplexer
  always_comb begin
    addr_ok = 1'b1;
    rd_byte = 8'h00;
    if (paddr != ADDR_W'(addr8)) begin
      addr_ok = 1'b0;
    end else if (addr8 == uarbs_pkg::OFF_CS_A) begin
      rd_byte[uarbs_pkg::A_RX_COMPLETE] = rx_complete_flag;
      rd_byte[uarbs_pkg::A_FRAME_ERR] = frame_error_flag;
      rd_byte[uarbs_pkg::A_OVERRUN] = overrun_flag;
      rd_byte[uarbs_pkg::A_PARITY_ERR] = parity_error_flag;
    end else if (addr8 == uarbs_pkg::OFF_CS_B) begin
      rd_byte = s.cs_b;
      rd_byte[uarbs_pkg::B_RX_NINTH] = rx_ninth_bit;
    end else if (addr8 == uarbs_pkg::OFF_CS_C) begin
      rd_byte = s.cs_c;
    end else if (addr8 == uarbs_pkg::OFF_RX_DATA) begin
      rd_byte = rx_data_byte;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // register state update: apb answer, control writes, outputs
  always_comb begin
    next_s = s;
    // zero-wait slave: ready rises in the first access cycle and drops
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.pop_armed = 1'b0;
    if (setup_phase) begin
      next_s.pready = 1'b1;
      next_s.pslverr = ~addr_ok;
      next_s.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      next_s.pop_armed = addr_ok & ~pwrite
                       & (addr8 == uarbs_pkg::OFF_RX_DATA)
                       & fifo_not_empty;
    end
    // writes land on the access edge; flag and data locations ignore them
    if (access_done && pwrite && addr_ok) begin
      if (addr8 == uarbs_pkg::OFF_CS_B) begin
        next_s.cs_b = (pwdata[7:0] & uarbs_pkg::CS_B_WMASK)
                    | (s.cs_b & ~uarbs_pkg::CS_B_WMASK);
      end else if (addr8 == uarbs_pkg::OFF_CS_C) begin
        next_s.cs_c = pwdata[7:0];
      end
      // ctrl_status_a writes are dropped so the flags stay intact
    end
    // interrupt follows the flag gated by its enable; error flags play no part
    next_s.irq = rx_complete_irq_enable & rx_complete_flag;
    next_s.override = rx_enable_bit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{cs_b: uarbs_pkg::CS_B_RESET,
             cs_c: uarbs_pkg::CS_C_RESET,
             prdata: 32'h0000_0000,
             pready: 1'b0,
             pslverr: 1'b0,
             pop_armed: 1'b0,
             irq: 1'b0,
             override: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign rx_complete_irq = s.irq;
  assign rx_pin_override = s.override;

endmodule : uarbs_top

// ==== verification/uarbs_props.sv ====
// port-level assertions for the receive buffer block
module uarbs_props #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_start,
  input wire logic bit_valid,
  input wire logic bit_value,
  input wire logic rx_complete_irq,
  input wire logic rx_pin_override
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc;
  logic setup;
  logic mapped;
  logic wr_b;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // decoded bus events
  assign acc = psel && penable && pready;
  assign setup = psel && !penable;
  assign mapped = paddr inside {uarbs_pkg::OFF_CS_A, uarbs_pkg::OFF_CS_B,
    uarbs_pkg::OFF_CS_C, uarbs_pkg::OFF_RX_DATA};
  assign wr_b = acc && pwrite && paddr == uarbs_pkg::OFF_CS_B;
  a_pready_access: assert property (
    setup |=> pready) else $error("no answer in access cycle");
  a_pready_single: assert property (
    pready |=> !pready) else $error("pready held too long");
  a_err_unmapped: assert property (
    setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (
    setup && mapped |=> !pslverr) else $error("mapped access refused");
  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_empty_flags: assert property (
    acc && !pwrite && paddr == uarbs_pkg::OFF_CS_A && !prdata[7]
    |-> prdata[4:2] == 3'h0 && !rx_complete_irq)
    else $error("flags or irq with empty buffer");
  a_irq_drop: assert property (
    wr_b && !(pwdata[7] && pwdata[4]) |=> ##2 !rx_complete_irq)
    else $error("irq after disable");
  a_pin_follow: assert property (
    wr_b |=> ##1 rx_pin_override == $past(pwdata[4], 2))
    else $error("pin override not following enable");
endmodule : uarbs_props

// ==== verification/uarbs_sender.sv ====
// remote transmitter model feeding recovered frame bits
module uarbs_sender (
  input wire logic pclk,
  output logic bit_start,
  output logic bit_valid,
  output logic bit_value
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    bit_start = 1'b0;
    bit_valid = 1'b0;
    bit_value = 1'b1;
  end
  // start pulse, data lsb first, parity, one stop; cut stops early
  task automatic send(input logic [8:0] d, input int n, input logic pen,
    input logic pb, input logic stp, input int cut);
    logic [10:0] f;
    int len;
    f = {2'h0, d};
    f[n] = pb;
    f[n+pen] = stp;
    len = n + pen + 1;
    @(posedge pclk);
    bit_start <= 1'b1;
    @(posedge pclk);
    bit_start <= 1'b0;
    for (int k = 0; k < len && k < cut; k++) begin
      @(posedge pclk);
      bit_valid <= 1'b1;
      bit_value <= f[k];
      @(posedge pclk);
      bit_valid <= 1'b0;
      bit_value <= ~f[k]; // stale level is not left showing
    end
  endtask : send
endmodule : uarbs_sender

// ==== verification/uarbs_top_tb.sv ====
// self-checking bench for the receive buffer and status block
module uarbs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] csz;
    logic pen;
    logic odd;
    logic bad;
    logic stp;
    logic [8:0] d;
  } uarbs_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, bit_start, bit_valid, bit_value, irq, pin;
  logic [31:0] rd;
  logic err;
  uarbs_row_t r;
  int n;
  logic [8:0] dm;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  // size codes 0..3, reserved and nine; parity off, even and odd; both stops
  uarbs_row_t rows [9] = '{16'h62a5, 16'h03f3, 16'h33c3, 16'h5eb7,
    16'hfb3c, 16'he155, 16'h76aa, 16'hc481, 16'hf7ff};
  always #25 pclk = ~pclk;
  uarbs_top #(.ADDR_W(8)) uarbs_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_start(bit_start), .bit_valid(bit_valid), .bit_value(bit_value),
    .rx_complete_irq(irq), .rx_pin_override(pin));
  uarbs_sender uarbs_sender_inst (.pclk(pclk), .bit_start(bit_start),
    .bit_valid(bit_valid), .bit_value(bit_value));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic print_verdict();
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // read status then data of one frame, software order kept
  task automatic rd_frame(input logic [7:0] st, input logic [7:0] dat);
    apb(0, uarbs_pkg::OFF_CS_A, 8'h00);
    chk(rd, {24'h0, st});
    apb(0, uarbs_pkg::OFF_RX_DATA, 8'h00);
    chk(rd, {24'h0, dat});
  endtask : rd_frame
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      n = r.csz == 3'h7 ? 9 : (r.csz > 3'h3 ? 8 : 5 + r.csz);
      dm = r.d & ((9'h1 << n) - 9'h1);
      apb(1, uarbs_pkg::OFF_CS_C,
        {2'h0, r.pen, r.odd, ~r.stp, r.csz[1:0], 1'h0});
      apb(1, uarbs_pkg::OFF_CS_B, {4'h9, 1'h0, r.csz[2], 2'h0});
      uarbs_sender_inst.send(r.d, n, r.pen, ^dm ^ r.odd ^ r.bad,
        r.stp, 99);
      // entry lands two edges after the stop pulse, irq one edge later
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(0, uarbs_pkg::OFF_CS_B, 8'h00);
      chk({31'h0, rd[1]}, {31'h0, dm[8]});
      rd_frame({1'h1, 2'h0, ~r.stp, 1'h0, r.pen & r.bad, 2'h0},
        dm[7:0]);
      apb(0, uarbs_pkg::OFF_CS_A, 8'h00);
      chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // overrun: two buffered, third waiting, fourth start drops it
    apb(1, uarbs_pkg::OFF_CS_C, 8'h06);
    // last row left the size msb set; back to eight-bit characters
    apb(1, uarbs_pkg::OFF_CS_B, 8'h90);
    for (int k = 1; k < 5; k++) begin
      uarbs_sender_inst.send(9'h010 + k, 8, 0, 0, 1, 99);
    end
    rd_frame(8'h80, 8'h11);
    rd_frame(8'h80, 8'h12);
    rd_frame(8'h88, 8'h14);
    uarbs_sender_inst.send(9'h055, 8, 0, 0, 1, 99);
    rd_frame(8'h80, 8'h55);
    // error flags ignore writes, even zeros over a set frame error
    uarbs_sender_inst.send(9'h0c3, 8, 0, 0, 0, 99);
    apb(1, uarbs_pkg::OFF_CS_A, 8'h00);
    rd_frame(8'h90, 8'hc3);
    apb(0, uarbs_pkg::OFF_CS_A, 8'h00);
    chk(rd, 32'h0);
    // drain by reading data until the complete flag drops
    uarbs_sender_inst.send(9'h021, 8, 0, 0, 1, 99);
    uarbs_sender_inst.send(9'h022, 8, 0, 0, 1, 99);
    n = 0;
    apb(0, uarbs_pkg::OFF_CS_A, 8'h00);
    while (rd[7] && n < 4) begin
      apb(0, uarbs_pkg::OFF_RX_DATA, 8'h00);
      n++;
      apb(0, uarbs_pkg::OFF_CS_A, 8'h00);
    end
    chk(32'(n), 32'h2);
    chk(rd, 32'h0);
    // disable mid-frame: buffer flushed, partial frame abandoned
    uarbs_sender_inst.send(9'h066, 8, 0, 0, 1, 99);
    uarbs_sender_inst.send(9'h03c, 8, 0, 0, 1, 4);
    apb(1, uarbs_pkg::OFF_CS_B, 8'h00);
    apb(0, uarbs_pkg::OFF_CS_A, 8'h00);
    chk(rd, 32'h0);
    chk({30'h0, irq, pin}, 32'h0);
    apb(1, uarbs_pkg::OFF_CS_B, 8'h92);
    apb(0, uarbs_pkg::OFF_CS_B, 8'h00);
    chk(rd, 32'h90);
    uarbs_sender_inst.send(9'h07e, 8, 0, 0, 1, 99);
    rd_frame(8'h80, 8'h7e);
    // unmapped access refused
    apb(0, 8'h10, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    // second reset restores register values
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, uarbs_pkg::OFF_CS_C, 8'h00);
    chk(rd, 32'h06);
    apb(0, uarbs_pkg::OFF_CS_B, 8'h00);
    chk({rd[30:0], pin}, 32'h0);
    print_verdict();
  end
endmodule : uarbs_top_tb
bind uarbs_top uarbs_props #(.ADDR_W(ADDR_W)) uarbs_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bit_start(bit_start),
  .bit_valid(bit_valid), .bit_value(bit_value),
  .rx_complete_irq(rx_complete_irq), .rx_pin_override(rx_pin_override));
